// ### core/pgfl_pkg.sv
// Constants for the power-good fault latch block.
package pgfl_pkg;
  localparam int NSRC = 7;
  localparam logic [7:0] OFS_FIRST_SEL   = 8'h18;
  localparam logic [7:0] OFS_FIRST_FLAG  = 8'h19;
  localparam logic [7:0] OFS_SECOND_SEL  = 8'h1a;
  localparam logic [7:0] OFS_SECOND_FLAG = 8'h1b;
  localparam logic [7:0] OFS_MODE        = 8'h17;
  localparam logic [7:0] OFS_IRQ_STAT    = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR     = 8'h21;
  localparam logic [7:0] OFS_IRQ_EN      = 8'h22;
  localparam int HOLD_BIT         = 7;
  localparam int MODE_SECOND_GATE = 6;
  localparam int MODE_SECOND_SENSE = 4;
  localparam int MODE_FIRST_GATE  = 2;
  localparam int MODE_FIRST_SENSE = 0;
  localparam logic [7:0] SEL_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int CLK_HZ     = 50_000_000;
  localparam int HOLD_MS    = 11;
  localparam int HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;
endpackage

// ### core/pgfl_rise_hold.sv
// Delays the rising edge of one good level.
`timescale 1ns/10ps
module pgfl_rise_hold
  import pgfl_pkg::*;
#(
  parameter int HOLD = HOLD_CYCLES
) (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic hold_en_i,
  input  wire logic good_i,
  output logic      good_o
);
  logic [31:0] cnt;
  wire         done = (cnt >= 32'(HOLD));
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt    <= 32'h0;
      good_o <= 1'b0;
    end else if (!good_i) begin
      cnt    <= 32'h0;
      good_o <= 1'b0;
    end else if (!hold_en_i || done) begin
      good_o <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule

// ### core/pgfl_top.sv
// Power-good combining, fault flags and register slave.
`timescale 1ns/10ps
module pgfl_top
  import pgfl_pkg::*;
#(
  parameter int HOLD = HOLD_CYCLES
) (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] avs_address_i,
  input  wire logic       avs_read_i,
  input  wire logic       avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0] avs_byteenable_i,
  output logic [31:0]     avs_readdata_o,
  output logic            avs_waitrequest_o,
  input  wire logic [6:0] src_valid_i,
  input  wire logic [6:0] second_sel_strap_i,
  output logic            first_good_output_o,
  output logic            second_good_output_o,
  output logic            irq_o
);
  logic [7:0] first_sel;
  logic [7:0] second_sel;
  logic [7:0] mode;
  logic [6:0] first_flags;
  logic [6:0] second_flags;
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  logic       ack;
  logic       first_held;
  logic       second_held;
  logic       strap_done;

  typedef enum logic [1:0] {
    PGFL_IDLE = 2'b00,
    PGFL_ACK  = 2'b01
  } pgfl_bus_t;
  pgfl_bus_t bus_state;

  function automatic logic all_ok(input logic [6:0] sel, input logic [6:0] v);
    all_ok = &(v | ~sel);
  endfunction

  wire       req      = avs_read_i | avs_write_i;
  wire       wr_go    = avs_write_i & (bus_state == PGFL_ACK);
  wire       be0      = avs_byteenable_i[0];
  wire [7:0] wd       = avs_writedata_i[7:0];
  wire       wr_fsel  = wr_go & be0 & (avs_address_i == OFS_FIRST_SEL);
  wire       wr_fflag = wr_go & be0 & (avs_address_i == OFS_FIRST_FLAG);
  wire       wr_ssel  = wr_go & be0 & (avs_address_i == OFS_SECOND_SEL);
  wire       wr_sflag = wr_go & be0 & (avs_address_i == OFS_SECOND_FLAG);
  wire       wr_mode  = wr_go & be0 & (avs_address_i == OFS_MODE);
  wire       wr_iclr  = wr_go & be0 & (avs_address_i == OFS_IRQ_CLR);
  wire       wr_ien   = wr_go & be0 & (avs_address_i == OFS_IRQ_EN);

  wire       first_live  = all_ok(first_sel[6:0], src_valid_i);
  wire       second_live = all_ok(second_sel[6:0], src_valid_i);
  wire [6:0] first_fail  = first_sel[6:0] & ~src_valid_i;
  wire [6:0] second_fail = second_sel[6:0] & ~src_valid_i;
  // clear only where source valid again
  wire [6:0] first_clr   = wr_fflag ? (wd[6:0] & src_valid_i) : 7'h00;
  wire [6:0] second_clr  = wr_sflag ? (wd[6:0] & src_valid_i) : 7'h00;
  wire       first_good  = mode[MODE_FIRST_GATE] ? (first_flags == 7'h00) : first_live;
  wire       second_good = mode[MODE_SECOND_GATE] ? (second_flags == 7'h00) : second_live;
  wire [1:0] irq_evt = {|second_fail, |first_fail};

  wire [7:0] rd_mux =
    (avs_address_i == OFS_FIRST_SEL)   ? first_sel :
    (avs_address_i == OFS_FIRST_FLAG)  ? {1'b0, first_flags} :
    (avs_address_i == OFS_SECOND_SEL)  ? second_sel :
    (avs_address_i == OFS_SECOND_FLAG) ? {1'b0, second_flags} :
    (avs_address_i == OFS_MODE)        ? mode :
    (avs_address_i == OFS_IRQ_STAT)    ? {6'h00, irq_stat} :
    (avs_address_i == OFS_IRQ_EN)      ? {6'h00, irq_en} : 8'h00;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      bus_state <= PGFL_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      case (bus_state)
        PGFL_IDLE: begin
          if (req) begin
            bus_state <= PGFL_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= {24'h0, rd_mux};
          end
        end
        PGFL_ACK: begin
          bus_state <= PGFL_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state <= PGFL_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      second_sel <= SEL_RESET;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      second_sel <= {1'b0, second_sel_strap_i};
      strap_done <= 1'b1;
    end else if (wr_ssel) begin
      second_sel <= wd;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      first_sel <= SEL_RESET;
      mode      <= MODE_RESET;
      irq_en    <= 2'b00;
    end else begin
      if (wr_fsel) first_sel <= wd;
      if (wr_mode) mode <= wd;
      if (wr_ien) irq_en <= wd[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      first_flags  <= 7'h00;
      second_flags <= 7'h00;
      irq_stat     <= 2'b00;
    end else begin
      first_flags  <= (first_flags & ~first_clr) | first_fail;
      second_flags <= (second_flags & ~second_clr) | second_fail;
      irq_stat     <= (irq_stat & ~(wr_iclr ? wd[1:0] : 2'b00)) | irq_evt;
    end
  end

  pgfl_rise_hold #(.HOLD(HOLD)) u_first_hold (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .hold_en_i (first_sel[HOLD_BIT]),
    .good_i    (first_good),
    .good_o    (first_held)
  );

  pgfl_rise_hold #(.HOLD(HOLD)) u_second_hold (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .hold_en_i (second_sel[HOLD_BIT]),
    .good_i    (second_good),
    .good_o    (second_held)
  );

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      first_good_output_o  <= 1'b0;
      second_good_output_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      first_good_output_o  <= first_held ^ mode[MODE_FIRST_SENSE];
      second_good_output_o <= second_held ^ mode[MODE_SECOND_SENSE];
      irq_o <= |(irq_stat & irq_en);
    end
  end

  chk_fail_sets_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    |second_fail |=> |second_flags) else $error("second flag not set");
  chk_first_flag_set: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (first_fail != 7'h00) |=> ((first_flags & $past(first_fail)) == $past(first_fail)))
    else $error("first flag not set");
  chk_invalid_keeps: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (second_flags[0] && !src_valid_i[0]) |=> second_flags[0]) else $error("flag lost");
  chk_first_keep: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (first_flags[6] && !src_valid_i[6]) |=> first_flags[6]) else $error("first flag lost");
  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (!avs_waitrequest_o && avs_address_i == OFS_SECOND_FLAG) |-> !avs_readdata_o[7])
    else $error("reserved bit set");
  chk_live_drop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (!mode[MODE_SECOND_GATE] && !second_live) |=> !second_held) else $error("live drop");
  chk_gate_mode: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (mode[MODE_FIRST_GATE] && first_flags != 7'h00) |=> !first_held) else $error("gate");
  chk_sense: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ##1 second_good_output_o == ($past(second_held) ^ $past(mode[MODE_SECOND_SENSE])))
    else $error("sense wrong");
  chk_no_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (!second_sel[HOLD_BIT] && second_good && !second_held) |=> second_held)
    else $error("undelayed rise late");
  chk_hold_min: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (first_sel[HOLD_BIT] && $rose(first_good)) |=> !first_held) else $error("early rise");
  chk_thermal_mask: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (!second_sel[6] && !second_flags[6]) |=> !second_flags[6]) else $error("thermal not masked");
  chk_select_mask: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (second_sel == 8'h00 && !mode[MODE_SECOND_GATE]) |=> second_held)
    else $error("mask ignored");
  chk_clear_lands: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (wr_fflag && wd[0] && src_valid_i[0] && !first_fail[0]) |=> !first_flags[0])
    else $error("first flag not cleared");
  chk_first_reserved: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (!avs_waitrequest_o && avs_address_i == OFS_FIRST_FLAG) |-> !avs_readdata_o[7])
    else $error("first reserved bit set");
  chk_second_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (second_sel[HOLD_BIT] && $rose(second_good)) |=> !second_held) else $error("early rise");
  chk_first_drop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (!mode[MODE_FIRST_GATE] && !first_live) |=> !first_held) else $error("first live drop");
  chk_second_gate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (mode[MODE_SECOND_GATE] && second_flags != 7'h00) |=> !second_held) else $error("gate");
  chk_strap_load: assert property (@(posedge mclk_i)
    ($rose(resetn_i)) |=> second_sel[6:0] == $past(second_sel_strap_i))
    else $error("strap not taken");

  cov_first_fault: cover property (@(posedge mclk_i) |first_flags);
  cov_second_clear: cover property (@(posedge mclk_i) $fell(|second_flags));
  cov_held_rise: cover property (@(posedge mclk_i) $rose(second_held));
  cov_irq: cover property (@(posedge mclk_i) irq_o);
endmodule

// ### sim/pgfl_src_model.sv
// Source-side model driving the live valid levels.
`timescale 1ns/10ps
module pgfl_src_model (
  input  wire logic       mclk_i,
  input  wire logic [6:0] fail_i,
  output logic      [6:0] src_valid_o = 7'h7f
);
  always @(posedge mclk_i) begin
    src_valid_o <= ~fail_i;
  end
endmodule

// ### sim/tb.sv
// Self-checking bench for the power-good fault latch.
`timescale 1ns/10ps
module tb;
  import pgfl_pkg::*;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [6:0]  src_valid_i;
  logic [6:0]  fail = 7'h00;
  logic [6:0]  strap = 7'h00;
  logic        first_good_output_o;
  logic        second_good_output_o;
  logic        irq_o;
  wire  [1:0]  goods = {second_good_output_o, first_good_output_o};
  logic [7:0]  r;
  logic [6:0]  s;
  logic [6:0]  f;
  logic [31:0] seed = 32'h5ead4921;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  always #10 mclk_i = ~mclk_i;
  pgfl_src_model u_src (.mclk_i(mclk_i), .fail_i(fail), .src_valid_o(src_valid_i));
  pgfl_top #(.HOLD(20)) u_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'h1), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .src_valid_i(src_valid_i),
    .second_sel_strap_i(strap), .first_good_output_o(first_good_output_o),
    .second_good_output_o(second_good_output_o), .irq_o(irq_o));
  function automatic logic [6:0] rnd7();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[6:0];
  endfunction
  // Output stays good unless a selected source fails
  function automatic logic exp_good(input logic [6:0] sel, input logic [6:0] bad);
    return ~|(sel & bad);
  endfunction
  task automatic final_report();
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), r, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    logic [7:0] sa;
    logic [7:0] fa;
    strap = rnd7();
    wt(6);
    resetn_i <= 1'b1;
    wt(3);
    rdchk(OFS_SECOND_SEL, {1'b0, strap});
    rdchk(OFS_SECOND_FLAG, 8'h00);
    rdchk(OFS_FIRST_FLAG, 8'h00);
    rdchk(8'h30, 8'h00);
    bus(1'b1, OFS_IRQ_EN, 8'h03);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 7; i++) begin
        sa = k ? OFS_SECOND_SEL : OFS_FIRST_SEL;
        fa = k ? OFS_SECOND_FLAG : OFS_FIRST_FLAG;
        bus(1'b1, sa, 8'h7f);
        bus(1'b1, k ? OFS_FIRST_SEL : OFS_SECOND_SEL, 8'h00);
        fail <= 7'h01 << i;
        wt(6);
        chk("good", {7'h00, goods[k]}, 8'h00);
        chk("irq", {7'h00, irq_o}, 8'h01);
        rdchk(OFS_IRQ_STAT, k ? 8'h02 : 8'h01);
        rdchk(fa, {1'b0, 7'h01 << i});
        bus(1'b1, sa, 8'h00);
        bus(1'b1, fa, 8'hff);
        rdchk(fa, {1'b0, 7'h01 << i});
        bus(1'b1, sa, 8'h7f);
        fail <= 7'h00;
        wt(4);
        bus(1'b1, fa, 8'hff);
        rdchk(fa, 8'h00);
        bus(1'b1, OFS_IRQ_CLR, 8'h03);
        wt(3);
        chk("irq", {7'h00, irq_o}, 8'h00);
        chk("good", {7'h00, goods[k]}, 8'h01);
      end
    end
    for (int n = 0; n < 8; n++) begin
      s = (n == 0) ? 7'h3f : rnd7();
      f = (n == 0) ? 7'h40 : 7'h01 << (rnd7() % 7);
      bus(1'b1, OFS_SECOND_SEL, {1'b0, s});
      fail <= f;
      wt(6);
      chk("good", {7'h00, second_good_output_o}, {7'h00, exp_good(s, f)});
      rdchk(OFS_SECOND_FLAG, {1'b0, s & f});
      fail <= 7'h00;
      wt(4);
      bus(1'b1, OFS_SECOND_FLAG, 8'hff);
      bus(1'b1, OFS_IRQ_CLR, 8'h03);
    end
    bus(1'b1, OFS_FIRST_SEL, 8'h7f);
    bus(1'b1, OFS_SECOND_SEL, 8'h7f);
    bus(1'b1, OFS_MODE, 8'h11);
    wt(4);
    chk("goods", {6'h00, goods}, 8'h00);
    bus(1'b1, OFS_MODE, 8'h44);
    fail <= 7'h01;
    wt(6);
    fail <= 7'h00;
    wt(6);
    chk("goods", {6'h00, goods}, 8'h00);
    bus(1'b1, OFS_FIRST_FLAG, 8'hff);
    bus(1'b1, OFS_SECOND_FLAG, 8'hff);
    wt(4);
    chk("goods", {6'h00, goods}, 8'h03);
    bus(1'b1, OFS_MODE, 8'h00);
    bus(1'b1, OFS_FIRST_SEL, 8'hff);
    bus(1'b1, OFS_SECOND_SEL, 8'hff);
    fail <= 7'h01;
    wt(6);
    fail <= 7'h00;
    wt(10);
    chk("goods", {6'h00, goods}, 8'h00);
    wt(20);
    chk("goods", {6'h00, goods}, 8'h03);
    final_report();
  end
endmodule
